// file: shared/irq_bank_pkg.sv
/*
  Constants for the interrupt flag and enable bank: register byte
  offsets, implemented-bit masks, reset values and bus answers.
  Assumes a 32-bit AXI4-Lite register bus with 8-bit addresses.
*/
package irq_bank_pkg;
  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          REG_W         = 16;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_FLAGS_1   = 8'h00;
  localparam logic [7:0]  OFF_FLAGS_3   = 8'h04;
  localparam logic [7:0]  OFF_FLAGS_4   = 8'h08;
  localparam logic [7:0]  OFF_ENABLES_0 = 8'h0c;
  localparam logic [7:0]  OFF_ENABLES_1 = 8'h10;
  localparam logic [7:0]  OFF_ENABLES_3 = 8'h14;
  localparam logic [7:0]  OFF_ENABLES_4 = 8'h18;
  localparam logic [7:0]  OFF_PRIO      = 8'h1c;
  localparam logic [7:0]  OFF_STATUS    = 8'h20;
  localparam logic [7:0]  OFF_MASK      = 8'h24;
  // ----------------------------------------------------------------
  // Implemented bits (1 = implemented, others read zero)
  // Flags 1: tx 15, rx 14, ext two 13, ext one 4, change 3,
  // comparator 2, i2c master 1, i2c slave 0.
  // Flags 3: rtcc 14. Flags 4: charge 13, voltage 8, crc 3,
  // uart b error 2, uart a error 1.
  // Enables 0: nvm 15, adc 13, tx 12, rx 11, spi 10, fault 9,
  // timers 8 and 7, timer one 3, compare 2, capture 1, ext zero 0.
  // ----------------------------------------------------------------
  localparam logic [15:0] IMPL_FLAGS_1  = 16'he01f;
  localparam logic [15:0] IMPL_FLAGS_3  = 16'h4000;
  localparam logic [15:0] IMPL_FLAGS_4  = 16'h210e;
  localparam logic [15:0] IMPL_EN_0     = 16'hbf8f;
  localparam logic [15:0] RST_REG       = 16'h0000;
  // ----------------------------------------------------------------
  // Priority fields: three bits per group, zero disables the group
  // ----------------------------------------------------------------
  localparam int          PRIO_W        = 3;
  localparam int          NGRP          = 4;
  localparam int          GRP_0         = 0;
  localparam int          GRP_1         = 1;
  localparam int          GRP_3         = 2;
  localparam int          GRP_4         = 3;
  localparam logic [2:0]  PRIO_OFF      = 3'h0;
  localparam logic [11:0] RST_PRIO      = 12'h924;
  localparam logic [3:0]  RST_NIB       = 4'h0;
endpackage

// file: design/flag_bits.sv
/*
  One sticky flag register: hardware set per bit, software write per
  byte lane, unimplemented bits held at zero.
  Assumes set pulses come from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module flag_bits
  import irq_bank_pkg::*;
#(
  parameter int          W    = 16,
  parameter logic [15:0] IMPL = 16'hffff
)(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic [W-1:0]  set,
  input  wire logic          wr_en,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [1:0]    wstrb,
  output logic      [W-1:0]  q
);
  typedef struct packed {
    logic [W-1:0] bits_ff;        // Flag bits.
  } state_t;
  state_t       cur;              // Registered state.
  state_t       nxt;              // Next state.
  logic [W-1:0] nxt_bits;         // Per-bit next values.
  // ----------------------------------------------------------------
  // Per-bit update
  // ----------------------------------------------------------------
  // A set in the same cycle as a software clear wins, so no event is
  // ever lost while software acknowledges an older one.
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    if (IMPL[i])
    begin : g_impl
      assign nxt_bits[i] = set[i] |
        ((wr_en && wstrb[i/8]) ? wdata[i] : cur.bits_ff[i]); // [R4] [R14]
    end
    else
    begin : g_none
      assign nxt_bits[i] = 1'b0; // [R3]
    end
  end
  // Next-state copy.
  always_comb
  begin
    nxt         = cur;
    nxt.bits_ff = nxt_bits;
  end
  // State register, cleared at reset.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '0; // [R4]
    else
      cur <= nxt;
  end
  assign q = cur.bits_ff;
endmodule // flag_bits
`default_nettype wire

// file: design/axil_port.sv
/*
  AXI4-Lite slave front end: one write and one read in flight,
  address and data taken in either order.
  Assumes the register side answers rd_data and the ok flags
  combinationally from the addresses it is given.
*/
`timescale 1ns/1ps
`default_nettype none
module axil_port
  import irq_bank_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [DATA_W-1:0] s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [DATA_W-1:0]      s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [DATA_W-1:0]      wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_ok,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_ok
);
  typedef struct packed {
    logic              aw_got;    // Write address held.
    logic              w_got;     // Write data held.
    logic [ADDR_W-1:0] awaddr;    // Held write address.
    logic [DATA_W-1:0] wdata;     // Held write data.
    logic [3:0]        wstrb;     // Held byte strobes.
    logic              bvalid;    // Write answer pending.
    logic [1:0]        bresp;     // Write answer code.
    logic              rvalid;    // Read answer pending.
    logic [1:0]        rresp;     // Read answer code.
    logic [DATA_W-1:0] rdata;     // Read answer data.
  } state_t;
  state_t cur;                    // Registered state.
  state_t nxt;                    // Next state.
  logic   rd_take;                // Read address taken now.
  // Ready terms hold off new requests until the answer is taken.
  assign s_awready = !cur.aw_got && !cur.bvalid;
  assign s_wready  = !cur.w_got && !cur.bvalid;
  assign s_arready = !cur.rvalid;
  assign rd_take   = s_arvalid && s_arready;
  assign wr_en     = cur.aw_got && cur.w_got;
  assign wr_addr   = cur.awaddr;
  assign wr_data   = cur.wdata;
  assign wr_strb   = cur.wstrb;
  assign rd_addr   = s_araddr;
  // ----------------------------------------------------------------
  // Channel sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt = cur;
    if (s_awvalid && s_awready)
    begin
      nxt.aw_got = 1'b1;
      nxt.awaddr = s_awaddr;
    end
    if (s_wvalid && s_wready)
    begin
      nxt.w_got = 1'b1;
      nxt.wdata = s_wdata;
      nxt.wstrb = s_wstrb;
    end
    // Unmapped addresses answer SLVERR and change nothing.
    if (wr_en)
    begin
      nxt.aw_got = 1'b0;
      nxt.w_got  = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (cur.bvalid && s_bready)
      nxt.bvalid = 1'b0;
    if (rd_take)
    begin
      nxt.rvalid = 1'b1;
      nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      nxt.rdata  = rd_ok ? rd_data : '0;
    end
    else if (cur.rvalid && s_rready)
      nxt.rvalid = 1'b0;
  end
  // State register.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '0;
    else
      cur <= nxt;
  end
  assign s_bvalid = cur.bvalid;
  assign s_bresp  = cur.bresp;
  assign s_rvalid = cur.rvalid;
  assign s_rresp  = cur.rresp;
  assign s_rdata  = cur.rdata;
endmodule // axil_port
`default_nettype wire

// file: design/irq_flag_enable_bank.sv
/*
  Interrupt flag and enable bank: three sticky flag registers, four
  enable registers, group priorities and a summary interrupt.
  Assumes event pulses and the outside flag word come from logic on
  core_clk; requests feed a priority resolver elsewhere.
*/
// What this block does
// R1: Flags 1 top bits: tx 15, rx 14, ext 13.
// R2: Flags 1 low bits: ext4, change3, cmp2, i2c1/0.
// R3: Unimplemented bits read zero, writes ignored.
// R4: Flags set by events, software read/write, reset zero.
// R5: Flag one means a request is pending.
// R6: Flags 3 holds only the rtcc flag, bit 14.
// R7: Flags 4: charge unit 13, voltage detect 8.
// R8: Flags 4: crc 3, uart errors 2,1.
// R9: Enable one permits, zero blocks; reset zero.
// R10: Enables 0 upper byte source placement.
// R11: Enables 0 lower byte placement, bits 6-4 empty.
// R12: Three-bit priority; zero disables the source.
// R13: Request only while flag and enable both set.
// R14: Software clears by writing zero; set wins.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_enable_bank
  import irq_bank_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [DATA_W-1:0] s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [DATA_W-1:0]      s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  input  wire logic [REG_W-1:0]  ev_flags_1,
  input  wire logic [REG_W-1:0]  ev_flags_3,
  input  wire logic [REG_W-1:0]  ev_flags_4,
  input  wire logic [REG_W-1:0]  ext_flags_0,
  output logic [REG_W-1:0]       req_0,
  output logic [REG_W-1:0]       req_1,
  output logic [REG_W-1:0]       req_3,
  output logic [REG_W-1:0]       req_4,
  output logic [11:0]            prio_levels,
  output logic                   irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [REG_W-1:0] en0_ff;     // Enables for outside flags.
    logic [REG_W-1:0] en1_ff;     // Enables for flags 1.
    logic [REG_W-1:0] en3_ff;     // Enables for flags 3.
    logic [REG_W-1:0] en4_ff;     // Enables for flags 4.
    logic [11:0]      prio_ff;    // Group priorities.
    logic [NGRP-1:0]  status_ff;  // Sticky group events.
    logic [NGRP-1:0]  mask_ff;    // Interrupt mask.
    logic [NGRP-1:0]  any_ff;     // Group request last cycle.
  } state_t;
  state_t           cur;          // Registered state.
  state_t           nxt;          // Next state.
  logic             wr_en;        // Register write strobe.
  logic [7:0]       wr_addr;      // Register write address.
  logic [31:0]      wr_data;      // Register write data.
  logic [3:0]       wr_strb;      // Register write strobes.
  logic             wr_ok;        // Write address is mapped.
  logic [7:0]       rd_addr;      // Register read address.
  logic [31:0]      rd_data;      // Register read data.
  logic             rd_ok;        // Read address is mapped.
  logic [15:0]      lane;         // Byte-lane bit mask.
  logic [15:0]      flags_1;      // Flags 1 contents.
  logic [15:0]      flags_3;      // Flags 3 contents.
  logic [15:0]      flags_4;      // Flags 4 contents.
  logic [NGRP-1:0]  grp_on;       // Group priority not zero.
  logic [NGRP-1:0]  grp_any;      // Group has a live request.
  // Every check below runs on core_clk and rests while reset is held.
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  axil_port u_port (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_ok),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );
  // Only the two low byte lanes carry register bits.
  assign lane = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  flag_bits #(.W(REG_W), .IMPL(IMPL_FLAGS_1)) u_flags_1 ( // [R1] [R2]
    .core_clk (core_clk),
    .nrst     (nrst),
    .set      (ev_flags_1 & IMPL_FLAGS_1),
    .wr_en    (wr_en && wr_addr == OFF_FLAGS_1),
    .wdata    (wr_data[15:0]),
    .wstrb    (wr_strb[1:0]),
    .q        (flags_1)
  );
  flag_bits #(.W(REG_W), .IMPL(IMPL_FLAGS_3)) u_flags_3 ( // [R6]
    .core_clk (core_clk),
    .nrst     (nrst),
    .set      (ev_flags_3 & IMPL_FLAGS_3),
    .wr_en    (wr_en && wr_addr == OFF_FLAGS_3),
    .wdata    (wr_data[15:0]),
    .wstrb    (wr_strb[1:0]),
    .q        (flags_3)
  );
  flag_bits #(.W(REG_W), .IMPL(IMPL_FLAGS_4)) u_flags_4 ( // [R7] [R8]
    .core_clk (core_clk),
    .nrst     (nrst),
    .set      (ev_flags_4 & IMPL_FLAGS_4),
    .wr_en    (wr_en && wr_addr == OFF_FLAGS_4),
    .wdata    (wr_data[15:0]),
    .wstrb    (wr_strb[1:0]),
    .q        (flags_4)
  );
  // ----------------------------------------------------------------
  // Requests toward priority resolution
  // ----------------------------------------------------------------
  // A zero priority silences the whole group, flags still latch.
  always_comb
  begin
    for (int g = 0; g < NGRP; g++)
      grp_on[g] = cur.prio_ff[g*PRIO_W +: PRIO_W] != PRIO_OFF; // [R12]
  end
  // A request stands only while both flag and enable are one.
  assign req_0 = ext_flags_0 & cur.en0_ff & {16{grp_on[GRP_0]}}; // [R13]
  assign req_1 = flags_1 & cur.en1_ff & {16{grp_on[GRP_1]}}; // [R13] [R9]
  assign req_3 = flags_3 & cur.en3_ff & {16{grp_on[GRP_3]}}; // [R13]
  assign req_4 = flags_4 & cur.en4_ff & {16{grp_on[GRP_4]}}; // [R13]
  assign grp_any = {|req_4, |req_3, |req_1, |req_0};
  assign prio_levels = cur.prio_ff;
  // Summary line is high while any unmasked status bit stands.
  assign irq = |(cur.status_ff & cur.mask_ff);
  // ----------------------------------------------------------------
  // Software-visible registers
  // ----------------------------------------------------------------
  // Writes merge by byte lane; implemented masks drop writes to
  // empty positions so they always read zero.
  always_comb
  begin
    nxt        = cur;
    nxt.any_ff = grp_any;
    if (wr_en)
    begin
      unique case (wr_addr)
        OFF_ENABLES_0:
          nxt.en0_ff = ((cur.en0_ff & ~lane) | (wr_data[15:0] & lane))
                       & IMPL_EN_0; // [R10] [R11] [R3] [R9]
        OFF_ENABLES_1:
          nxt.en1_ff = ((cur.en1_ff & ~lane) | (wr_data[15:0] & lane))
                       & IMPL_FLAGS_1; // [R9] [R3]
        OFF_ENABLES_3:
          nxt.en3_ff = ((cur.en3_ff & ~lane) | (wr_data[15:0] & lane))
                       & IMPL_FLAGS_3; // [R9] [R3]
        OFF_ENABLES_4:
          nxt.en4_ff = ((cur.en4_ff & ~lane) | (wr_data[15:0] & lane))
                       & IMPL_FLAGS_4; // [R9] [R3]
        OFF_PRIO:
          nxt.prio_ff = (cur.prio_ff & ~lane[11:0])
                        | (wr_data[11:0] & lane[11:0]);
        OFF_STATUS:
          if (wr_strb[0])
            nxt.status_ff = cur.status_ff & ~wr_data[3:0];
        OFF_MASK:
          if (wr_strb[0])
            nxt.mask_ff = wr_data[3:0];
        default:
          nxt.any_ff = grp_any;
      endcase
    end
    // A group that starts requesting is latched, winning over a
    // write-one clear in the same cycle.
    nxt.status_ff = nxt.status_ff | (grp_any & ~cur.any_ff);
  end
  // Decode of mapped addresses.
  assign wr_ok = wr_addr inside {OFF_FLAGS_1, OFF_FLAGS_3, OFF_FLAGS_4,
    OFF_ENABLES_0, OFF_ENABLES_1, OFF_ENABLES_3, OFF_ENABLES_4,
    OFF_PRIO, OFF_STATUS, OFF_MASK};
  assign rd_ok = rd_addr inside {OFF_FLAGS_1, OFF_FLAGS_3, OFF_FLAGS_4,
    OFF_ENABLES_0, OFF_ENABLES_1, OFF_ENABLES_3, OFF_ENABLES_4,
    OFF_PRIO, OFF_STATUS, OFF_MASK};
  // Read mux; upper bits of every word read zero.
  always_comb
  begin
    rd_data = '0;
    unique case (rd_addr)
      OFF_FLAGS_1:   rd_data[15:0] = flags_1; // [R5]
      OFF_FLAGS_3:   rd_data[15:0] = flags_3; // [R5]
      OFF_FLAGS_4:   rd_data[15:0] = flags_4; // [R5]
      OFF_ENABLES_0: rd_data[15:0] = cur.en0_ff;
      OFF_ENABLES_1: rd_data[15:0] = cur.en1_ff;
      OFF_ENABLES_3: rd_data[15:0] = cur.en3_ff;
      OFF_ENABLES_4: rd_data[15:0] = cur.en4_ff;
      OFF_PRIO:      rd_data[11:0] = cur.prio_ff;
      OFF_STATUS:    rd_data[3:0]  = cur.status_ff;
      OFF_MASK:      rd_data[3:0]  = cur.mask_ff;
      default:       rd_data       = '0;
    endcase
  end
  // State register; priorities come up at a mid level.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur           <= '0; // [R9]
      cur.prio_ff   <= RST_PRIO;
      cur.status_ff <= RST_NIB;
    end
    else
      cur <= nxt;
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic full_wr;                  // Full-strobe write now.
  assign full_wr = wr_en && wr_strb == 4'hf;
  a_tx_flag_pos: assert property ( // [R1]
    ev_flags_1[15] |=> flags_1[15])
    else $error("Flag 15 of flags 1 did not set.");
  a_slave_flag_pos: assert property ( // [R2]
    ev_flags_1[0] && !ev_flags_1[1] && !(wr_en && wr_addr == OFF_FLAGS_1)
    && !flags_1[1] |=> flags_1[0] && !flags_1[1])
    else $error("Flags 1 low bits misplaced.");
  a_empty_bits_zero: assert property ( // [R3]
    (flags_1 & ~IMPL_FLAGS_1) == 16'h0000
    && (flags_3 & ~IMPL_FLAGS_3) == 16'h0000
    && (flags_4 & ~IMPL_FLAGS_4) == 16'h0000
    && (cur.en0_ff & ~IMPL_EN_0) == 16'h0000)
    else $error("Unimplemented bit became set.");
  a_set_beats_clear: assert property ( // [R14]
    wr_en && wr_addr == OFF_FLAGS_1 && wr_strb[1] && !wr_data[14]
    && ev_flags_1[14] |=> flags_1[14])
    else $error("Software clear beat a hardware set.");
  a_clear_by_zero: assert property ( // [R4]
    wr_en && wr_addr == OFF_FLAGS_4 && wr_strb[1] && !wr_data[13]
    && !ev_flags_4[13] |=> !flags_4[13])
    else $error("Flag write of zero did not clear.");
  a_rtcc_only: assert property ( // [R6]
    ev_flags_3 == 16'hffff |=> (flags_3 & 16'h4000) == 16'h4000
    && (flags_3 & 16'hbfff) == 16'h0000)
    else $error("Flags 3 layout wrong.");
  a_voltage_pos: assert property ( // [R7]
    ev_flags_4[8] |=> flags_4[8])
    else $error("Voltage detect flag did not set.");
  a_crc_pos: assert property ( // [R8]
    ev_flags_4 == 16'h00ff |=> (flags_4 & 16'h00ff) == 16'h000e)
    else $error("Flags 4 low byte wrong.");
  a_en0_layout: assert property ( // [R10]
    full_wr && wr_addr == OFF_ENABLES_0 && wr_data[15:0] == 16'hffff
    |=> cur.en0_ff == 16'hbf8f)
    else $error("Enables 0 layout wrong.");
  a_prio_off: assert property ( // [R12]
    !grp_on[GRP_1] |-> req_1 == 16'h0000)
    else $error("Disabled group raised a request.");
  a_req_follows: assert property ( // [R13]
    ev_flags_1[15] && cur.en1_ff[15] && grp_on[GRP_1] && !wr_en
    |=> req_1[15])
    else $error("Enabled flag gave no request.");
  a_status_latch: assert property ( // [R9]
    $rose(|req_1) && cur.mask_ff[GRP_1]
    && !(wr_en && wr_addr == OFF_MASK) |=> irq)
    else $error("Unmasked event did not raise irq.");
endmodule // irq_flag_enable_bank
`default_nettype wire

// file: tb/ev_src.sv
/* Event source model: one-cycle set pulses for the flag bank.
   Assumes fire and pat change just after core_clk edges. */
`timescale 1ns/1ps
`default_nettype none
module ev_src
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        fire,
  input  wire logic [15:0] pat,
  output logic      [15:0] ev
);
  // Pulse for one cycle per fire so a held level cannot mask a clear.
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) ev <= 16'h0000;
    else ev <= fire ? pat : 16'h0000;
endmodule // ev_src
`default_nettype wire

// file: tb/irq_flag_enable_bank_tb.sv
/* Self-checking bench for the flag and enable bank.
   Assumes the AXI4-Lite slave answers within 50 cycles. */
`timescale 1ns/1ps
`default_nettype none
module irq_flag_enable_bank_tb;
  import irq_bank_pkg::*;
  logic core_clk = 0, nrst = 0, fire = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, v, seed = 32'd77686;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] pat = 0, ext = 0, ev, req_0, req_1, req_3, req_4;
  logic [11:0] prio;
  logic [3:0] strb = 4'hf;
  logic [7:0] offs [4] = '{OFF_FLAGS_1, OFF_FLAGS_3, OFF_FLAGS_4,
                           OFF_ENABLES_0};
  logic [15:0] msk [4] = '{IMPL_FLAGS_1, IMPL_FLAGS_3, IMPL_FLAGS_4,
                           IMPL_EN_0};
  int failures = 0, total_checks = 0, i, j;
  initial forever #50 core_clk = ~core_clk;
  ev_src ev_src_inst (.core_clk, .nrst, .fire, .pat, .ev);
  irq_flag_enable_bank irq_flag_enable_bank_inst (.core_clk, .nrst,
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(strb), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready), .ev_flags_1(ev),
    .ev_flags_3(ev), .ev_flags_4(ev), .ext_flags_0(ext), .req_0,
    .req_1, .req_3, .req_4, .prio_levels(prio), .irq);
  // Xorshift stream; the fixed seed keeps runs repeatable.
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Readback of a word: only implemented bits survive.
  function logic [31:0] ex(input logic [15:0] w, m);
    return {16'h0, w & m};
  endfunction
  task chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 50)
    begin
      failures++;
      $display("[ERR] %0t bus answer missing", $time);
      conclude;
    end
  endtask
  // Write: address and data offered together, each dropped when taken.
  task wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    awaddr <= a; wdata <= w; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    r = bresp; bready <= 0; tmo(n);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] w, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    w = rdata; r = rresp; rready <= 0; tmo(n);
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    nrst <= 1;
    for (i = 0; i < 4; i++)
    begin
      rd(offs[i], d, resp); chk(d, 32'h0);
    end
    rd(OFF_PRIO, d, resp); chk(d, {20'h0, RST_PRIO});
    // All-ones corner first, then random words.
    for (i = 0; i < 12; i++)
    begin
      v = (i < 4) ? 32'hffffffff : rnd();
      wr(offs[i%4], v, resp); rd(offs[i%4], d, resp);
      chk(d, ex(v[15:0], msk[i%4]));
    end
    $display("test registers done");
    for (i = 0; i < 3; i++) wr(offs[i], 32'h0, resp);
    wr(OFF_ENABLES_0, 32'hffff, resp);
    wr(OFF_ENABLES_1, 32'hffff, resp);
    wr(OFF_MASK, 32'h2, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    ext <= 16'hffff; pat <= 16'hffff; fire <= 1;
    @(posedge core_clk); fire <= 0;
    repeat (4) @(posedge core_clk);
    for (i = 0; i < 3; i++)
    begin
      rd(offs[i], d, resp); chk(d, {16'h0, msk[i]});
    end
    chk({16'h0, req_1}, {16'h0, IMPL_FLAGS_1});
    chk({16'h0, req_3}, 32'h0);
    chk({16'h0, req_4}, 32'h0);
    chk({16'h0, req_0}, {16'h0, IMPL_EN_0});
    chk({31'h0, irq}, 32'h1);
    wr(OFF_STATUS, 32'h2, resp); @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_PRIO, 32'h904, resp); @(posedge core_clk);
    chk({16'h0, req_1}, 32'h0);
    $display("test requests done");
    chk({20'h0, prio}, 32'h904);
    // Corner event patterns first, then random ones; each flag word is
    // read back and cleared so the next pattern starts from zero.
    for (i = 0; i < 3; i++) wr(offs[i], 32'h0, resp);
    for (i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 32'h00ff : (i == 1) ? 32'h1 : rnd();
      pat <= v[15:0]; fire <= 1;
      @(posedge core_clk); fire <= 0;
      repeat (2) @(posedge core_clk);
      for (j = 0; j < 3; j++)
      begin
        rd(offs[j], d, resp); chk(d, ex(v[15:0], msk[j]));
        wr(offs[j], 32'h0, resp);
      end
    end
    // An event in the cycle of a clearing write must survive it.
    pat <= 16'h4000;
    fork
      wr(OFF_FLAGS_1, 32'h0, resp);
      begin
        @(posedge core_clk); fire <= 1;
        @(posedge core_clk); fire <= 0;
      end
    join
    rd(OFF_FLAGS_1, d, resp); chk(d, 32'h4000);
    // Only byte lane 0 written: the upper enables keep their zeros.
    wr(OFF_ENABLES_0, 32'h0, resp); strb <= 4'h1;
    wr(OFF_ENABLES_0, 32'hffff, resp); strb <= 4'hf;
    rd(OFF_ENABLES_0, d, resp); chk(d, ex(16'h00ff, IMPL_EN_0));
    $display("test events done");
    wr(8'h3c, 32'h1, resp); chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(8'h3c, d, resp); chk(d, 32'h0);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    $display("test unmapped done");
    conclude;
  end
endmodule // irq_flag_enable_bank_tb
`default_nettype wire
